/* File: rtl/tunnel_defines.svh */
// constants for the serial tunnel packer and dtr control
// assumes inclusion by bare name from rtl files
`ifndef TUNNEL_DEFINES_SVH
`define TUNNEL_DEFINES_SVH
// apb register byte offsets
`define REG_CTRL 12'h000
`define REG_THRESH 12'h004
`define REG_TIMEOUT 12'h008
`define REG_CHARS 12'h00c
`define REG_STATUS 12'h010
`define REG_BUFSIZE 12'h014
// ctrl field positions
`define CTRL_PACK_LO 0
`define CTRL_PACK_HI 1
`define CTRL_DTR_LO 2
`define CTRL_DTR_HI 3
`define CTRL_TRAIL_EN 4
// reset values
`define THRESH_RST 8'h08
`define TIMEOUT_RST 16'h000a
`define BUFSIZE_RST 4'h8
// timing: one millisecond at 125 MHz
`define MS_NS 1000000
`define CLK_NS 8
`define MS_CYCLES 17'd125000
// fifo geometry
`define FIFO_DEPTH 8
`define FIFO_AW 3
`endif

/* File: rtl/tunnel_pkg.sv */
// types shared by the tunnel packer
// assumes the defines header is available
package tunnel_pkg;
	// packing mode selection
	typedef enum logic [1:0] {
		PACK_OFF = 2'h0,
		PACK_TIMEOUT = 2'h1,
		PACK_SENDCHAR = 2'h2
	} pack_mode_e;
	// dtr mode selection
	typedef enum logic [1:0] {
		DTR_NEVER = 2'h0,
		DTR_REMOTE = 2'h1,
		DTR_CONNECTED = 2'h2,
		DTR_ALWAYS = 2'h3
	} dtr_mode_e;
endpackage

/* File: rtl/byte_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
// assumes a single clock and synchronous active high reset
`timescale 1ns/10ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// occupancy
	output logic [AW:0] count
);
	logic [WIDTH-1:0] mem_r [DEPTH]; // storage words
	logic [AW-1:0] wr_r; // write index
	logic [AW-1:0] rd_r; // read index
	logic [AW:0] cnt_r; // words held
	logic push; // accepted write
	logic pop; // accepted read
	// honest full and empty from the count
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
	assign count = cnt_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// storage write
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end
	// pointers wrap naturally; depth is a power of two
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= rd_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule // byte_fifo

/* File: rtl/serial_tunnel_packer_dtr.sv */
// serial tunnel packer: buffers serial bytes, releases packets, drives dtr
// assumes serial bytes arrive as one-cycle strobes in the sys_clk domain,
// connection state inputs are synchronous levels, registers over apb
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "tunnel_defines.svh"
// Behaviour
// - serial bytes held in size-limited receive buffer
// - buffered bytes forwarded while connection active
// - dtr has four selectable modes
// - remote mode: connected and remote dsr asserted
// - connected mode: dtr while accept or connect
// - always mode: dtr asserted unconditionally
// - packing mode off, timeout or send char
// - threshold reached releases packet at once
// - timeout mode releases after configured milliseconds
// - send character releases packet immediately
// - optional trailing character in send char mode
// - send character included after data bytes
// - trailing character follows send character
// - threshold in timeout and sendchar, not off
module serial_tunnel_packer_dtr (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial receive byte stream
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	// connection state
	input wire logic accept_up,
	input wire logic connect_up,
	input wire logic remote_dsr_follow,
	// network side stream
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	// modem control
	output logic dtr
);
	// release state machine
	typedef enum logic [3:0] {
		ST_FILL = 4'h1,
		ST_SEND = 4'h2,
		ST_TRAIL = 4'h4,
		ST_WAIT = 4'h8
	} pk_state_e;
	pk_state_e state_r; // packet phase
	logic [31:0] ctrl_r; // mode fields
	logic [7:0] thresh_r; // byte threshold
	logic [15:0] timeout_r; // timeout in ms
	logic [7:0] send_char_r; // send character
	logic [7:0] trail_char_r; // trailing character
	logic [3:0] bufsize_r; // buffer capacity limit
	logic [7:0] queued_r; // bytes in current packet
	logic [16:0] tick_r; // ms prescaler
	logic [15:0] ms_r; // elapsed ms
	logic timing_r; // timer running
	logic release_r; // packet armed for release
	logic [7:0] pend_r; // bytes still to drain for the packet
	logic sc_pend_r; // a send char ends the packet
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic tx_valid_r;
	logic [7:0] tx_data_r;
	logic tx_last_r;
	logic dtr_r;
	logic rx_ready_r;
	// fifo wiring
	logic f_in_valid;
	logic f_in_ready;
	logic f_out_valid;
	logic f_out_ready;
	logic [7:0] f_out_data;
	logic [`FIFO_AW:0] f_count;
	logic take; // byte accepted from serial
	logic is_send_char; // accepted byte equals send char
	logic hit_thresh; // threshold reached on this byte
	logic hit_timeout; // timer expired
	logic apb_wr; // write access phase
	logic connected; // either tunnel up
	tunnel_pkg::pack_mode_e pmode;
	tunnel_pkg::dtr_mode_e dmode;
	logic trail_en;
	logic tx_fire; // tx register free or drained

	// address in map check, used by the error path
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == `REG_CTRL) || (a == `REG_THRESH) ||
			(a == `REG_TIMEOUT) || (a == `REG_CHARS) ||
			(a == `REG_STATUS) || (a == `REG_BUFSIZE);
	endfunction

	assign pmode = tunnel_pkg::pack_mode_e'(ctrl_r[`CTRL_PACK_HI:`CTRL_PACK_LO]);
	assign dmode = tunnel_pkg::dtr_mode_e'(ctrl_r[`CTRL_DTR_HI:`CTRL_DTR_LO]);
	assign trail_en = ctrl_r[`CTRL_TRAIL_EN];
	assign connected = accept_up || connect_up;
	// a write lands at the edge where the master sees pready high
	assign apb_wr = psel && penable && pwrite && pready_r;
	assign tx_fire = !tx_valid_r || tx_ready;

	// limiting capacity to bufsize gives software the buffer size knob
	assign f_in_valid = rx_valid && (f_count < {1'b0, bufsize_r}) &&
		(state_r == ST_FILL);
	assign take = f_in_valid && f_in_ready;
	assign is_send_char = (pmode == tunnel_pkg::PACK_SENDCHAR) &&
		(rx_data == send_char_r);
	assign hit_thresh = (pmode != tunnel_pkg::PACK_OFF) &&
		(queued_r + 8'h01 >= thresh_r);
	assign hit_timeout = (pmode == tunnel_pkg::PACK_TIMEOUT) && timing_r &&
		(ms_r >= timeout_r);

	byte_fifo #(
		.WIDTH(8),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(rx_data),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data),
		.count(f_count)
	);

	// drain only bytes of a released packet into the tx register
	assign f_out_ready = connected && (state_r == ST_SEND) &&
		(pend_r != 8'h00) && tx_fire;

	// serial ready mirrors what the fill side would accept
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rx_ready_r <= 1'b0;
		end else begin
			rx_ready_r <= f_in_ready && (state_r == ST_FILL) &&
				(f_count < {1'b0, bufsize_r});
		end
	end
	assign rx_ready = rx_ready_r;

	// apb register writes
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ctrl_r <= '0;
			thresh_r <= `THRESH_RST;
			timeout_r <= `TIMEOUT_RST;
			send_char_r <= '0;
			trail_char_r <= '0;
			bufsize_r <= `BUFSIZE_RST;
		end else if (apb_wr) begin
			case (paddr)
				`REG_CTRL: ctrl_r <= {27'h0, pwdata[4:0]};
				`REG_THRESH: thresh_r <= pwdata[7:0];
				`REG_TIMEOUT: timeout_r <= pwdata[15:0];
				`REG_CHARS: begin
					send_char_r <= pwdata[7:0];
					trail_char_r <= pwdata[15:8];
				end
				`REG_BUFSIZE: begin
					// zero or above depth would break the limit compare
					if (pwdata[3:0] != 4'h0 && pwdata[3:0] <= `BUFSIZE_RST) begin
						bufsize_r <= pwdata[3:0];
					end
				end
				default: ;
			endcase
		end
	end

	// apb answer: one wait state, read data registered
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			pready_r <= psel && penable && !pready_r;
			pslverr_r <= psel && penable && !pready_r && !mapped(paddr);
			prdata_r <= '0;
			if (psel && penable && !pready_r && !pwrite) begin
				case (paddr)
					`REG_CTRL: prdata_r <= ctrl_r;
					`REG_THRESH: prdata_r <= {24'h0, thresh_r};
					`REG_TIMEOUT: prdata_r <= {16'h0, timeout_r};
					`REG_CHARS: prdata_r <= {16'h0, trail_char_r, send_char_r};
					`REG_STATUS: prdata_r <= {12'h0, state_r, 4'h0,
						f_count[3:0], queued_r};
					`REG_BUFSIZE: prdata_r <= {28'h0, bufsize_r};
					default: prdata_r <= '0;
				endcase
			end
		end
	end
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// packet phase and queued count
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r <= ST_FILL;
			queued_r <= '0;
			pend_r <= '0;
			sc_pend_r <= 1'b0;
		end else begin
			case (state_r)
				ST_FILL: begin
					if (take && (pmode == tunnel_pkg::PACK_OFF)) begin
						state_r <= ST_SEND;
						pend_r <= 8'h01;
						sc_pend_r <= 1'b0;
						queued_r <= '0;
					end else if (take && (is_send_char || hit_thresh)) begin
						state_r <= ST_SEND;
						pend_r <= queued_r + 8'h01;
						sc_pend_r <= is_send_char;
						queued_r <= '0;
					end else if (hit_timeout && queued_r != 8'h00) begin
						state_r <= ST_SEND;
						// a byte landing as the timer expires joins this packet,
						// otherwise it would sit in the fifo uncounted
						pend_r <= queued_r + {7'h00, take};
						sc_pend_r <= 1'b0;
						queued_r <= '0;
					end else if (take) begin
						queued_r <= queued_r + 8'h01;
					end
				end
				ST_SEND: begin
					if (f_out_valid && f_out_ready) begin
						pend_r <= pend_r - 8'h01;
						if (pend_r == 8'h01) begin
							state_r <= (sc_pend_r && trail_en) ? ST_TRAIL : ST_WAIT;
						end
					end
				end
				ST_TRAIL: begin
					if (tx_fire) begin
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (tx_fire) begin
						state_r <= ST_FILL;
					end
				end
				default: state_r <= ST_FILL;
			endcase
		end
	end

	// millisecond timer, started by a packet's first byte
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			timing_r <= 1'b0;
			tick_r <= '0;
			ms_r <= '0;
		end else if (state_r != ST_FILL || hit_timeout) begin
			timing_r <= 1'b0;
			tick_r <= '0;
			ms_r <= '0;
		end else if (take && !timing_r) begin
			timing_r <= 1'b1;
			tick_r <= '0;
			ms_r <= '0;
		end else if (timing_r) begin
			if (tick_r == `MS_CYCLES - 17'd1) begin
				tick_r <= '0;
				ms_r <= ms_r + 16'h0001;
			end else begin
				tick_r <= tick_r + 17'd1;
			end
		end
	end

	// tx output register; trailing char is injected after the send char
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tx_valid_r <= 1'b0;
			tx_data_r <= '0;
			tx_last_r <= 1'b0;
		end else if (f_out_valid && f_out_ready) begin
			tx_valid_r <= 1'b1;
			tx_data_r <= f_out_data;
			tx_last_r <= (pend_r == 8'h01) && !(sc_pend_r && trail_en);
		end else if (state_r == ST_TRAIL && tx_fire) begin
			tx_valid_r <= 1'b1;
			tx_data_r <= trail_char_r;
			tx_last_r <= 1'b1;
		end else if (tx_ready) begin
			tx_valid_r <= 1'b0;
			tx_last_r <= 1'b0;
		end
	end
	assign tx_valid = tx_valid_r;
	assign tx_data = tx_data_r;
	assign tx_last = tx_last_r;

	// dtr mode select
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dtr_r <= 1'b0;
		end else begin
			case (dmode)
				tunnel_pkg::DTR_NEVER: dtr_r <= 1'b0;
				tunnel_pkg::DTR_REMOTE: dtr_r <= connected && remote_dsr_follow;
				tunnel_pkg::DTR_CONNECTED: dtr_r <= connected;
				tunnel_pkg::DTR_ALWAYS: dtr_r <= 1'b1;
				default: dtr_r <= 1'b0;
			endcase
		end
	end
	assign dtr = dtr_r;

	// assertions
	property p_dtr_always;
		@(posedge sys_clk) disable iff (reset)
		(dmode == tunnel_pkg::DTR_ALWAYS) |=> dtr;
	endproperty
	a_dtr_always: assert property (p_dtr_always) else $error("dtr low in always mode");
	property p_dtr_conn;
		@(posedge sys_clk) disable iff (reset)
		(dmode == tunnel_pkg::DTR_CONNECTED) && $stable(dmode) |=> (dtr == $past(connected));
	endproperty
	a_dtr_conn: assert property (p_dtr_conn) else $error("dtr not tracking link");
	property p_dtr_remote;
		@(posedge sys_clk) disable iff (reset)
		(dmode == tunnel_pkg::DTR_REMOTE) && !remote_dsr_follow |=> !dtr;
	endproperty
	a_dtr_remote: assert property (p_dtr_remote) else $error("dtr high without dsr");
	property p_dtr_never;
		@(posedge sys_clk) disable iff (reset)
		(dmode == tunnel_pkg::DTR_NEVER) |=> !dtr;
	endproperty
	a_dtr_never: assert property (p_dtr_never) else $error("dtr high in never mode");
	property p_sendchar;
		@(posedge sys_clk) disable iff (reset)
		take && is_send_char |=> (state_r == ST_SEND) && sc_pend_r;
	endproperty
	a_sendchar: assert property (p_sendchar) else $error("send char no release");
	property p_thresh;
		@(posedge sys_clk) disable iff (reset)
		take && hit_thresh |=> (state_r == ST_SEND) && (queued_r == 8'h00);
	endproperty
	a_thresh: assert property (p_thresh) else $error("threshold no release");
	property p_off;
		@(posedge sys_clk) disable iff (reset)
		take && (pmode == tunnel_pkg::PACK_OFF) |=> (pend_r == 8'h01);
	endproperty
	a_off: assert property (p_off) else $error("off mode held byte");
	property p_bufsize;
		@(posedge sys_clk) disable iff (reset)
		(f_count >= {1'b0, bufsize_r}) |=> (f_count <= $past(f_count));
	endproperty
	a_bufsize: assert property (p_bufsize) else $error("buffer over limit");
	property p_timer_stop;
		@(posedge sys_clk) disable iff (reset)
		(state_r == ST_SEND) |=> !timing_r;
	endproperty
	a_timer_stop: assert property (p_timer_stop) else $error("timer ran after release");
endmodule // serial_tunnel_packer_dtr

/* File: tb/net_sink.sv */
// network peer model: takes the packed byte stream and logs every byte
// assumes the stream runs on sys_clk and a byte moves on valid and ready
`timescale 1ns/10ps
module net_sink (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// packet stream from the packer
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready,
	// pacing chosen by the bench
	input wire logic slow
);
	logic tog_r; // alternates so a slow peer takes every other cycle
	logic [8:0] q[$]; // received bytes, end-of-packet flag on top

	// pacing toggle, a slow peer stalls the packer half the time
	always_ff @(posedge sys_clk) begin
		if (reset)
			tog_r <= 1'b0;
		else
			tog_r <= ~tog_r;
	end
	assign tx_ready = !slow || tog_r;

	// log each byte that really moved, in order
	always_ff @(posedge sys_clk) begin
		if (!reset && tx_valid && tx_ready)
			q.push_back({tx_last, tx_data});
	end
endmodule // net_sink

/* File: tb/tb_serial_tunnel_packer_dtr.sv */
// self-checking bench for the serial tunnel packer and dtr control
// assumes the net_sink peer model and the design's defines header
`timescale 1ns/10ps
`include "tunnel_defines.svh"
module tb_serial_tunnel_packer_dtr;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	// apb master side
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	// serial bytes, link state, network stream
	logic rx_valid = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic rx_ready;
	logic accept_up = 1'b0;
	logic connect_up = 1'b0;
	logic remote_dsr_follow = 1'b0;
	logic tx_valid;
	logic [7:0] tx_data;
	logic tx_last;
	logic tx_ready;
	logic dtr;
	logic slow = 1'b0; // peer pacing
	logic [31:0] rd_data; // data of the last read
	logic rd_err; // error flag of the last transfer
	int num_errors = 0;
	int checks_done = 0;
	// dtr rows: mode, accept, connect, remote dsr, expected dtr
	logic [5:0] dtr_rows [8] = '{
		{tunnel_pkg::DTR_NEVER, 4'b1110}, {tunnel_pkg::DTR_REMOTE, 4'b1011},
		{tunnel_pkg::DTR_REMOTE, 4'b0100}, {tunnel_pkg::DTR_REMOTE, 4'b0010},
		{tunnel_pkg::DTR_CONNECTED, 4'b0101},
		{tunnel_pkg::DTR_CONNECTED, 4'b1001},
		{tunnel_pkg::DTR_CONNECTED, 4'b0010},
		{tunnel_pkg::DTR_ALWAYS, 4'b0001}};

	// 125 MHz clock
	always #4 sys_clk = ~sys_clk;

	serial_tunnel_packer_dtr uut (.sys_clk(sys_clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .accept_up(accept_up), .connect_up(connect_up),
		.remote_dsr_follow(remote_dsr_follow), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.dtr(dtr));

	net_sink sink (.sys_clk(sys_clk), .reset(reset), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.slow(slow));

	// verdict and end of run, also reached by any expired wait
	task automatic finish_test;
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// the one comparison, four-state so an unknown never matches
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			finish_test();
		end
	endtask

	// one serial byte, presented for a single cycle
	task automatic rx(input logic [7:0] b);
		@(posedge sys_clk);
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge sys_clk);
		rx_valid <= 1'b0;
	endtask

	// next byte seen by the peer, with its end-of-packet flag
	task automatic pop(input logic [8:0] e);
		int n;
		n = 0;
		while (sink.q.size() == 0 && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		if (sink.q.size() == 0) begin
			num_errors++;
			finish_test();
		end
		chk({23'h0, sink.q.pop_front()}, {23'h0, e});
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		chk({30'h0, dtr, tx_valid}, 32'h0);
		// register reset values and an unmapped address
		apb(1'b0, `REG_CTRL, 32'h0);
		chk(rd_data, 32'h0);
		chk({31'h0, rx_ready}, 32'h1);
		apb(1'b0, `REG_THRESH, 32'h0);
		chk(rd_data, 32'h8);
		apb(1'b0, `REG_TIMEOUT, 32'h0);
		chk(rd_data, 32'ha);
		apb(1'b1, 12'h018, 32'h5);
		apb(1'b0, 12'h018, 32'h0);
		chk({rd_err, rd_data[30:0]}, 32'h80000000);
		// ordinary cases: every dtr mode against the link state
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `REG_CTRL, {28'h0, dtr_rows[i][5:4], 2'h0});
			accept_up <= dtr_rows[i][3];
			connect_up <= dtr_rows[i][2];
			remote_dsr_follow <= dtr_rows[i][1];
			repeat (3) @(posedge sys_clk);
			chk({31'h0, dtr}, {31'h0, dtr_rows[i][0]});
		end
		// mid-run reset returns dtr and control to idle
		reset <= 1'b1;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		chk({31'h0, dtr}, 32'h0);
		apb(1'b0, `REG_CTRL, 32'h0);
		chk(rd_data, 32'h0);
		// buffer limit: oversize setting refused, fill with no link up
		apb(1'b1, `REG_BUFSIZE, 32'h9);
		apb(1'b0, `REG_BUFSIZE, 32'h0);
		chk(rd_data, 32'h8);
		apb(1'b1, `REG_TIMEOUT, 32'hffff);
		apb(1'b1, `REG_CTRL, {30'h0, tunnel_pkg::PACK_TIMEOUT});
		for (int i = 0; i < 10; i++)
			rx(8'h30 + i[7:0]);
		apb(1'b0, `REG_STATUS, 32'h0);
		chk({28'h0, rd_data[11:8]}, 32'h8);
		chk({31'h0, rx_ready}, 32'h0);
		// link comes up while the peer stalls every other cycle
		slow <= 1'b1;
		connect_up <= 1'b1;
		for (int i = 0; i < 8; i++)
			pop({i == 7, 8'h30 + i[7:0]});
		repeat (20) @(posedge sys_clk);
		chk(sink.q.size(), 32'h0);
		apb(1'b0, `REG_STATUS, 32'h0);
		chk({24'h0, rd_data[7:0]}, 32'h0);
		// packing off: each byte leaves alone
		slow <= 1'b0;
		apb(1'b1, `REG_CTRL, 32'h0);
		rx(8'h55);
		pop({1'b1, 8'h55});
		rx(8'h56);
		pop({1'b1, 8'h56});
		// threshold of three in send character mode
		apb(1'b1, `REG_THRESH, 32'h3);
		apb(1'b1, `REG_CHARS, 32'h0a0d);
		apb(1'b1, `REG_CTRL, {30'h0, tunnel_pkg::PACK_SENDCHAR});
		for (int i = 0; i < 3; i++)
			rx(8'h61 + i[7:0]);
		for (int i = 0; i < 3; i++)
			pop({i == 2, 8'h61 + i[7:0]});
		// send character then trailing character end the packet
		apb(1'b1, `REG_THRESH, 32'h8);
		apb(1'b1, `REG_CTRL, 32'h12);
		rx(8'h41);
		rx(8'h0d);
		pop({1'b0, 8'h41});
		pop({1'b0, 8'h0d});
		pop({1'b1, 8'h0a});
		// zero timeout releases the first byte on its own
		apb(1'b1, `REG_TIMEOUT, 32'h0);
		apb(1'b1, `REG_CTRL, {30'h0, tunnel_pkg::PACK_TIMEOUT});
		rx(8'h77);
		pop({1'b1, 8'h77});
		repeat (20) @(posedge sys_clk);
		chk(sink.q.size(), 32'h0);
		// a byte landing on the expiry edge must join that packet
		@(posedge sys_clk);
		rx_valid <= 1'b1;
		rx_data <= 8'h78;
		@(posedge sys_clk);
		rx_data <= 8'h79;
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		pop({1'b0, 8'h78});
		pop({1'b1, 8'h79});
		repeat (20) @(posedge sys_clk);
		chk(sink.q.size(), 32'h0);
		finish_test();
	end
endmodule // tb_serial_tunnel_packer_dtr
